/* File: inc/crf_pkg.sv */
// Package: register map, field layout and types of the CAN receive flag block
`default_nettype none
package crf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  // Register offsets
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_FULL_LO = 4'h1;
  localparam logic [3:0] OFS_FULL_HI = 4'h2;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFS_IRQ_EN = 4'h4;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h5;
  localparam logic [3:0] OFS_MB_BASE = 4'h6;
  localparam logic [3:0] OFS_TX_CTRL = 4'h7;
  localparam logic [3:0] OFS_TX_DESC = 4'h8;
  localparam logic [3:0] OFS_TX_ID = 4'h9;
  localparam logic [3:0] OFS_MEM_ADDR = 4'hA;
  localparam logic [3:0] OFS_MEM_DATA = 4'hB;
  // Event flag field layout (low byte of the flag register)
  localparam logic [7:0] FLAG_MASK = 8'hEF;
  localparam int ERR_STAT_LSB = 8;
  // Buffer word 0 layout
  localparam int W0_SID_LSB = 2;
  localparam int W0_SID_MSB = 12;
  localparam int W0_RTR_BIT = 1;
  localparam int W0_EXT_BIT = 0;
  localparam logic [15:0] W0_MASK = 16'h1FFF;
  // Buffer word 1 layout
  localparam logic [15:0] W1_MASK = 16'h0FFF;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Interrupt status bit positions
  localparam int IRQ_RX_LSB = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_EVT_BIT = 2;
  localparam int IRQ_W = 3;

  typedef struct packed {
    logic tx_bus_off_status;
    logic tx_bus_passive_status;
    logic rx_bus_passive_status;
    logic tx_error_warning_status;
    logic rx_error_warning_status;
  } crf_err_type;

  typedef struct packed {
    logic invalid_message_flag;
    logic bus_wakeup_flag;
    logic error_event_flag;
    logic queue_almost_full_flag;
    logic rx_overflow_flag;
    logic rx_buffer_event_flag;
    logic tx_buffer_event_flag;
  } crf_evt_type;

  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic [15:0] word0;
    logic [15:0] word1;
  } crf_rx_type;

  typedef struct packed {
    logic [10:0] short_identifier_field;
    logic [11:0] long_identifier_field;
    logic remote;
    logic tx_long_format_select;
  } crf_txd_type;
endpackage : crf_pkg
`default_nettype wire

/* File: rtl/crf_ram.sv */
// Module: DMA-side message buffer memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module crf_ram (
  input wire logic clock_i,
  input wire logic wr_i,
  input wire logic [crf_pkg::MEM_AW-1:0] waddr_i,
  input wire logic [crf_pkg::DATA_W-1:0] wdata_i,
  input wire logic [crf_pkg::MEM_AW-1:0] raddr_i,
  output logic [crf_pkg::DATA_W-1:0] rdata_o
);
  logic [crf_pkg::DATA_W-1:0] mem_r [crf_pkg::MEM_DEPTH];

  always_ff @(posedge clock_i) begin
    if (wr_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    rdata_o <= mem_r[raddr_i];
  end
endmodule : crf_ram
`default_nettype wire

/* File: rtl/crf_txfmt.sv */
// Module: decoder of buffer words 0 and 1 into a transmit descriptor
`timescale 1ns/100ps
`default_nettype none
module crf_txfmt (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [crf_pkg::DATA_W-1:0] word0_i,
  input wire logic [crf_pkg::DATA_W-1:0] word1_i,
  output crf_pkg::crf_txd_type desc_o
);
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      desc_o <= '0;
    end else if (load_i) begin
      desc_o.short_identifier_field <=
        word0_i[crf_pkg::W0_SID_MSB:crf_pkg::W0_SID_LSB];
      desc_o.tx_long_format_select <= word0_i[crf_pkg::W0_EXT_BIT];
      // Remote request only meaningful for short format
      desc_o.remote <= word0_i[crf_pkg::W0_RTR_BIT] &
        ~word0_i[crf_pkg::W0_EXT_BIT];
      desc_o.long_identifier_field <= word1_i[11:0];
    end
  end
endmodule : crf_txfmt
`default_nettype wire

/* File: rtl/crf_top.sv */
// Module: CAN receive-full tracking, event flags and message buffer words
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - A stored received message sets the full bit of its slot 0 to 31.
// - Full and flag bits clear only on a written zero; a written one keeps.
// - Message buffers live in a memory reached as plain words.
// - Word 0 holds the short identifier in bits 12..2; bits 15..13 are 0.
// - In short format word 0 bit 1 requests a remote frame.
// - Word 0 bit 0 selects long (1) or short (0) identifier format.
// - Word 1 holds long id bits 17..6 in bits 11..0; bits 15..12 are 0.
module crf_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [crf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [crf_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [crf_pkg::DATA_W-1:0] rdata_o,
  input wire crf_pkg::crf_rx_type rx_i,
  input wire crf_pkg::crf_evt_type evt_i,
  input wire crf_pkg::crf_err_type err_i,
  output crf_pkg::crf_txd_type tx_desc_o,
  output logic tx_req_o,
  output logic irq_o
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [1:0] {
    TX_IDLE, TX_RD0, TX_RD1, TX_DONE
  } crf_txst_type;

  crf_txst_type tx_state_r;
  logic [15:0] full_lo_r;
  logic [15:0] full_hi_r;
  logic [6:0] evt_flags_r;
  logic [crf_pkg::IRQ_W-1:0] irq_stat_r;
  logic [crf_pkg::IRQ_W-1:0] irq_en_r;
  logic [crf_pkg::MEM_AW-1:0] mb_base_r;
  logic [crf_pkg::MEM_AW-1:0] tx_slot_r;
  logic [crf_pkg::MEM_AW-1:0] mem_ptr_r;
  logic [15:0] word0_r;
  logic [31:0] rx_set;
  logic [6:0] evt_vec;
  logic [6:0] flags_wr;
  logic [crf_pkg::IRQ_W-1:0] irq_set;
  logic ram_wr;
  logic [crf_pkg::MEM_AW-1:0] ram_waddr;
  logic [15:0] ram_wdata;
  logic [crf_pkg::MEM_AW-1:0] ram_raddr;
  logic [15:0] ram_rdata;
  logic rx_phase_r;
  logic [15:0] rx_w1_r;
  logic [crf_pkg::MEM_AW-1:0] rx_addr_r;
  logic tx_start;
  logic rd_mem_r;
  logic [15:0] rdata_nxt;
  logic [15:0] rd_reg_r;

  // Register select used by several processes
  function automatic logic wr_hit(input logic w, input logic [3:0] a,
                                  input logic [3:0] ofs);
    wr_hit = w && (a == ofs);
  endfunction : wr_hit

  // Buffer word address: two words per slot above the base
  function automatic logic [crf_pkg::MEM_AW-1:0] slot_addr(
    input logic [crf_pkg::MEM_AW-1:0] base,
    input logic [4:0] slot, input logic odd);
    slot_addr = base + {2'b00, slot, odd};
  endfunction : slot_addr

  // ****************************************************************
  // Receive-full bits
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_rxset
      assign rx_set[g] = rx_i.valid && (rx_i.slot == 5'(g));
    end
  endgenerate

  // Set wins over a same-cycle clear; zero written clears, one keeps
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      full_lo_r <= crf_pkg::ZERO16;
    end else if (wr_hit(wr_i, addr_i, crf_pkg::OFS_FULL_LO)) begin
      full_lo_r <= (full_lo_r & wdata_i) | rx_set[15:0];
    end else begin
      full_lo_r <= full_lo_r | rx_set[15:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      full_hi_r <= crf_pkg::ZERO16;
    end else if (wr_hit(wr_i, addr_i, crf_pkg::OFS_FULL_HI)) begin
      full_hi_r <= (full_hi_r & wdata_i) | rx_set[31:16];
    end else begin
      full_hi_r <= full_hi_r | rx_set[31:16];
    end
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************
  assign evt_vec = evt_i;
  // Reserved bit 4 dropped from the packed 7-bit flag vector
  assign flags_wr = {wdata_i[7:5], wdata_i[3:0]};

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      evt_flags_r <= '0;
    end else if (wr_hit(wr_i, addr_i, crf_pkg::OFS_FLAGS)) begin
      evt_flags_r <= (evt_flags_r & flags_wr) | evt_vec;
    end else begin
      evt_flags_r <= evt_flags_r | evt_vec;
    end
  end

  // ****************************************************************
  // Interrupt status, enable and clear
  // ****************************************************************
  assign irq_set = {|evt_vec, tx_start, rx_i.valid};

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (wr_hit(wr_i, addr_i, crf_pkg::OFS_IRQ_CLR)) begin
      irq_stat_r <= (irq_stat_r & ~wdata_i[crf_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_en_r <= '0;
    end else if (wr_hit(wr_i, addr_i, crf_pkg::OFS_IRQ_EN)) begin
      irq_en_r <= wdata_i[crf_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_r & irq_en_r);

  // ****************************************************************
  // Buffer area control
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mb_base_r <= '0;
      tx_slot_r <= '0;
      mem_ptr_r <= '0;
    end else begin
      if (wr_hit(wr_i, addr_i, crf_pkg::OFS_MB_BASE)) begin
        mb_base_r <= wdata_i[crf_pkg::MEM_AW-1:0];
      end
      if (wr_hit(wr_i, addr_i, crf_pkg::OFS_TX_CTRL)) begin
        tx_slot_r <= wdata_i[crf_pkg::MEM_AW-1:0];
      end
      if (wr_hit(wr_i, addr_i, crf_pkg::OFS_MEM_ADDR)) begin
        mem_ptr_r <= wdata_i[crf_pkg::MEM_AW-1:0];
      end else if (wr_hit(wr_i, addr_i, crf_pkg::OFS_MEM_DATA) ||
                   (rd_i && addr_i == crf_pkg::OFS_MEM_DATA)) begin
        // Auto-increment lets software stream a buffer
        mem_ptr_r <= mem_ptr_r + 8'h01;
      end
    end
  end

  // Received word 1 is written one cycle after word 0
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_phase_r <= 1'b0;
      rx_w1_r <= '0;
      rx_addr_r <= '0;
    end else begin
      rx_phase_r <= rx_i.valid;
      rx_w1_r <= rx_i.word1 & crf_pkg::W1_MASK;
      rx_addr_r <= slot_addr(mb_base_r, rx_i.slot, 1'b1);
    end
  end

  // Memory write arbitration: receive first, then software
  always_comb begin
    ram_wr = 1'b0;
    ram_waddr = mem_ptr_r;
    ram_wdata = wdata_i;
    if (rx_i.valid) begin
      ram_wr = 1'b1;
      ram_waddr = slot_addr(mb_base_r, rx_i.slot, 1'b0);
      ram_wdata = rx_i.word0 & crf_pkg::W0_MASK;
    end else if (rx_phase_r) begin
      ram_wr = 1'b1;
      ram_waddr = rx_addr_r;
      ram_wdata = rx_w1_r;
    end else if (wr_hit(wr_i, addr_i, crf_pkg::OFS_MEM_DATA)) begin
      ram_wr = 1'b1;
    end
  end

  // ****************************************************************
  // Transmit fetch
  // ****************************************************************
  assign tx_start = wr_hit(wr_i, addr_i, crf_pkg::OFS_TX_CTRL);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_state_r <= TX_IDLE;
    end else begin
      unique case (tx_state_r)
        TX_IDLE: begin
          if (tx_start) begin
            tx_state_r <= TX_RD0;
          end
        end
        TX_RD0: begin
          tx_state_r <= TX_RD1;
        end
        TX_RD1: begin
          tx_state_r <= TX_DONE;
        end
        TX_DONE: begin
          tx_state_r <= TX_IDLE;
        end
      endcase
    end
  end

  // Software reads use the port except in the fetch start cycle and TX_RD0
  always_comb begin
    ram_raddr = mem_ptr_r;
    if (tx_state_r == TX_IDLE && tx_start) begin
      ram_raddr = slot_addr(mb_base_r, wdata_i[4:0], 1'b0);
    end else if (tx_state_r == TX_RD0) begin
      ram_raddr = slot_addr(mb_base_r, tx_slot_r[4:0], 1'b1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      word0_r <= '0;
    end else if (tx_state_r == TX_RD0) begin
      word0_r <= ram_rdata;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_req_o <= 1'b0;
    end else begin
      tx_req_o <= (tx_state_r == TX_RD1);
    end
  end

  crf_ram u_ram (
    .clock_i(clock_i),
    .wr_i(ram_wr),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(ram_raddr),
    .rdata_o(ram_rdata)
  );

  crf_txfmt u_fmt (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(tx_state_r == TX_RD1),
    .word0_i(word0_r),
    .word1_i(ram_rdata),
    .desc_o(tx_desc_o)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_nxt = crf_pkg::ZERO16;
    unique case (addr_i)
      crf_pkg::OFS_FLAGS: rdata_nxt = {2'b00, err_i,
        err_i.tx_error_warning_status | err_i.rx_error_warning_status,
        evt_flags_r[6:4], 1'b0, evt_flags_r[3:0]};
      crf_pkg::OFS_FULL_LO: rdata_nxt = full_lo_r;
      crf_pkg::OFS_FULL_HI: rdata_nxt = full_hi_r;
      crf_pkg::OFS_IRQ_STAT: rdata_nxt = {13'h0000, irq_stat_r};
      crf_pkg::OFS_IRQ_EN: rdata_nxt = {13'h0000, irq_en_r};
      crf_pkg::OFS_MB_BASE: rdata_nxt = {crf_pkg::ZERO8, mb_base_r};
      crf_pkg::OFS_TX_CTRL: rdata_nxt = {crf_pkg::ZERO8, tx_slot_r};
      crf_pkg::OFS_TX_DESC: rdata_nxt = {2'b00, tx_desc_o.remote,
        tx_desc_o.tx_long_format_select, 1'b0,
        tx_desc_o.short_identifier_field};
      crf_pkg::OFS_TX_ID: rdata_nxt = {4'h0,
        tx_desc_o.long_identifier_field};
      crf_pkg::OFS_MEM_ADDR: rdata_nxt = {crf_pkg::ZERO8, mem_ptr_r};
      default: rdata_nxt = crf_pkg::ZERO16;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_reg_r <= '0;
      rd_mem_r <= 1'b0;
    end else begin
      rd_reg_r <= rd_i ? rdata_nxt : crf_pkg::ZERO16;
      rd_mem_r <= rd_i && (addr_i == crf_pkg::OFS_MEM_DATA);
    end
  end

  assign rdata_o = rd_mem_r ? ram_rdata : rd_reg_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking crf_cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_full_set_lo: assert property (rx_i.valid && !rx_i.slot[4] |=>
    full_lo_r[$past(rx_i.slot[3:0])])
    else $error("full bit not set on receive");
  a_full_set_hi: assert property (rx_i.valid && rx_i.slot[4] |=>
    full_hi_r[$past(rx_i.slot[3:0])])
    else $error("high full bit not set on receive");
  a_full_hold: assert property (
    !wr_hit(wr_i, addr_i, crf_pkg::OFS_FULL_LO) |=>
    (full_lo_r & $past(full_lo_r)) == $past(full_lo_r))
    else $error("full bit dropped without software clear");
  a_flag_one_keep: assert property (
    wr_hit(wr_i, addr_i, crf_pkg::OFS_FLAGS) |=>
    (evt_flags_r & $past(flags_wr & evt_flags_r)) ==
    $past(flags_wr & evt_flags_r))
    else $error("writing one changed a clear-only flag");
  a_flag_latch: assert property (
    evt_i.error_event_flag |=> evt_flags_r[4] [*1])
    else $error("event flag not latched");
  a_rx_word0_mask: assert property (
    ram_wr |-> !(rx_i.valid && (ram_wdata & ~crf_pkg::W0_MASK) != 0))
    else $error("word 0 upper bits not zero");
  a_tx_remote_fmt: assert property (
    tx_req_o |-> !(tx_desc_o.remote && tx_desc_o.tx_long_format_select))
    else $error("remote set in long format");
  a_tx_req_time: assert property (
    tx_state_r == TX_IDLE && tx_start |-> ##3 tx_req_o)
    else $error("transmit request not issued three cycles after start");
  a_rx_word1_mem: assert property (
    rx_i.valid |=> ram_wr && (ram_wdata & ~crf_pkg::W1_MASK) == 0)
    else $error("word 1 not written or upper bits set");
  a_irq_level: assert property (
    (irq_o == |(irq_stat_r & irq_en_r)) and ($rose(irq_o) |->
    $past(|irq_set) || $past(wr_hit(wr_i, addr_i, crf_pkg::OFS_IRQ_EN))))
    else $error("interrupt without cause");

  c_rx_store: cover property (@(posedge clock_i) rx_i.valid ##1 rx_phase_r);
  c_tx_fetch: cover property (@(posedge clock_i) tx_start ##3 tx_req_o);
  c_set_clear: cover property (@(posedge clock_i)
    rx_i.valid && wr_hit(wr_i, addr_i, crf_pkg::OFS_FULL_LO));
  c_irq: cover property (@(posedge clock_i) $rose(irq_o));
endmodule : crf_top
`default_nettype wire

/* File: tb/crf_node_model.sv */
// Partner model: far-side network nodes delivering frames and error state
`timescale 1ns/100ps
`default_nettype none
module crf_node_model (
  input wire logic clock_i,
  input wire logic rst_i,
  output var crf_pkg::crf_rx_type rx_o,
  output var crf_pkg::crf_evt_type evt_o,
  output var crf_pkg::crf_err_type err_o
);
  initial begin
    rx_o = '0;
    evt_o = '0;
    err_o = '0;
  end

  // Words turn over after release so a stale frame never looks valid
  task automatic deliver(input logic [4:0] slot, input logic [15:0] w0,
                         input logic [15:0] w1);
    while (rst_i) @(posedge clock_i);
    @(posedge clock_i);
    rx_o <= '{valid: 1'b1, slot: slot, word0: w0, word1: w1};
    @(posedge clock_i);
    rx_o <= '{valid: 1'b0, slot: ~slot, word0: ~w0, word1: ~w1};
    // Keeps the minimum spacing between stored frames
    @(posedge clock_i);
  endtask : deliver

  task automatic pulse(input crf_pkg::crf_evt_type e);
    @(posedge clock_i);
    evt_o <= e;
    @(posedge clock_i);
    evt_o <= '0;
  endtask : pulse

  task automatic set_err(input crf_pkg::crf_err_type e);
    @(posedge clock_i);
    err_o <= e;
  endtask : set_err
endmodule : crf_node_model
`default_nettype wire

/* File: tb/crf_top_tb_top.sv */
// Testbench: register-level checks of the receive flag block
`timescale 1ns/100ps
`default_nettype none
module crf_top_tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  crf_pkg::crf_rx_type rx;
  crf_pkg::crf_evt_type evt;
  crf_pkg::crf_err_type err;
  crf_pkg::crf_txd_type tx_desc;
  crf_pkg::crf_txd_type expd;
  logic tx_req;
  logic irq;
  logic found;
  logic [15:0] w0s [3];
  logic [15:0] w1s [3];
  int n_errors = 0;
  int checked = 0;

  always #12.5 clock_i = ~clock_i;

  crf_top DUT (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_i(rx), .evt_i(evt),
    .err_i(err), .tx_desc_o(tx_desc), .tx_req_o(tx_req), .irq_o(irq)
  );

  crf_node_model node (
    .clock_i(clock_i), .rst_i(rst_i), .rx_o(rx), .evt_o(evt), .err_o(err)
  );

  // ****************************************
  // Bus access and comparison
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    check({16'h0000, rdata}, {16'h0000, e});
  endtask : rd_chk

  task automatic final_report;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // Generous bound; the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    final_report;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    w0s = '{16'h1FFC, 16'h0AAA, 16'h1557};
    w1s = '{16'h0555, 16'h0FFF, 16'h0ABC};
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd_chk(i[3:0], 16'h0000);
    end
    rd_chk(4'hC, 16'h0000);
    wr_reg(crf_pkg::OFS_MB_BASE, 16'h0010);
    wr_reg(crf_pkg::OFS_IRQ_EN, 16'h0001);
    rd_chk(crf_pkg::OFS_IRQ_EN, 16'h0001);
    // Receive into both full registers
    node.deliver(5'h03, 16'hFFFF, 16'hFFFF);
    node.deliver(5'h14, 16'h1234, 16'hABCD);
    #1;
    check({31'h0, irq}, 32'h1);
    rd_chk(crf_pkg::OFS_FULL_LO, 16'h0008);
    rd_chk(crf_pkg::OFS_FULL_HI, 16'h0010);
    rd_chk(crf_pkg::OFS_IRQ_STAT, 16'h0001);
    wr_reg(crf_pkg::OFS_FULL_LO, 16'hFFFF);
    rd_chk(crf_pkg::OFS_FULL_LO, 16'h0008);
    wr_reg(crf_pkg::OFS_FULL_HI, 16'hFFEF);
    rd_chk(crf_pkg::OFS_FULL_HI, 16'h0000);
    wr_reg(crf_pkg::OFS_FULL_LO, 16'hFFF7);
    rd_chk(crf_pkg::OFS_FULL_LO, 16'h0000);
    // Stored words in memory, reserved bits zero
    wr_reg(crf_pkg::OFS_MEM_ADDR, 16'h0016);
    rd_chk(crf_pkg::OFS_MEM_DATA, 16'h1FFF);
    rd_chk(crf_pkg::OFS_MEM_DATA, 16'h0FFF);
    wr_reg(crf_pkg::OFS_MEM_ADDR, 16'h0038);
    rd_chk(crf_pkg::OFS_MEM_DATA, 16'h1234);
    rd_chk(crf_pkg::OFS_MEM_DATA, 16'h0BCD);
    wr_reg(crf_pkg::OFS_IRQ_CLR, 16'h0007);
    #1;
    check({31'h0, irq}, 32'h0);
    // Event flags and live error state
    node.set_err(5'h15);
    node.pulse(7'h7F);
    rd_chk(crf_pkg::OFS_FLAGS, 16'h2BEF);
    #1;
    check({31'h0, irq}, 32'h0);
    wr_reg(crf_pkg::OFS_IRQ_EN, 16'h0004);
    #1;
    check({31'h0, irq}, 32'h1);
    wr_reg(crf_pkg::OFS_FLAGS, 16'hFFFE);
    rd_chk(crf_pkg::OFS_FLAGS, 16'h2BEE);
    wr_reg(crf_pkg::OFS_FLAGS, 16'hFF00);
    rd_chk(crf_pkg::OFS_FLAGS, 16'h2B00);
    wr_reg(crf_pkg::OFS_IRQ_EN, 16'h0000);
    // Transmit: short data, short remote, long format
    for (int i = 0; i < 3; i++) begin
      wr_reg(crf_pkg::OFS_MEM_ADDR, 16'h0020 + 16'(4 * i));
      wr_reg(crf_pkg::OFS_MEM_DATA, w0s[i]);
      wr_reg(crf_pkg::OFS_MEM_DATA, w1s[i]);
      wr_reg(crf_pkg::OFS_TX_CTRL, 16'h0008 + 16'(2 * i));
      found = 1'b0;
      for (int k = 0; k < 20 && !found; k++) begin
        @(posedge clock_i);
        #1;
        if (tx_req === 1'b1) found = 1'b1;
      end
      check({31'h0, found}, 32'h1);
      expd.short_identifier_field = w0s[i][12:2];
      expd.long_identifier_field = w1s[i][11:0];
      expd.remote = w0s[i][1] & ~w0s[i][0];
      expd.tx_long_format_select = w0s[i][0];
      check({7'h0, tx_desc}, {7'h0, expd});
      rd_chk(crf_pkg::OFS_TX_DESC, {2'h0, expd.remote,
        expd.tx_long_format_select, 1'h0, expd.short_identifier_field});
      rd_chk(crf_pkg::OFS_TX_ID, {4'h0, expd.long_identifier_field});
    end
    final_report;
  end
endmodule : crf_top_tb_top
`default_nettype wire
